// file: rtl/core_mode_stack_registers.v
`timescale 1ns/1ns
`include "core_state_defines.vh"

// Functional notes
// - after reset the core starts in application mode.
// - handlers run in handler mode; return only when none outstanding.
// - active stack pointer always addresses the last pushed item.
// - each push stores at the pointer minus four first, then moves the pointer there.
// - separate main and process stack pointers, updated independently.
// - handler mode always uses the main stack pointer.
// - application mode picks the stack pointer by a control bit.
// - control bit 1 zero selects main stack, one process; resets zero.
// - thirteen 32-bit general registers, read/write, undefined after reset.
// - exception entry pushes the caller context in hardware.
// - a multi-word transfer hit by an exception restarts from first word.
// - reset loads main stack pointer from the word at address zero.
// - reset loads instruction pointer from address four, bit 0 to state.
module core_mode_stack_registers
(
  input  wire        clk_sys,
  input  wire        reset,
  // register access port
  input  wire [4:0]  reg_sel,
  input  wire        reg_wr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  // execution unit requests
  input  wire        push_req,
  input  wire [31:0] push_data,
  input  wire        flags_wr,
  input  wire [3:0]  flags_in,
  input  wire        pc_wr,
  input  wire [31:0] pc_in,
  input  wire        multi_busy,
  input  wire [31:0] multi_start_pc,
  input  wire        exc_req,
  input  wire [5:0]  exc_num,
  input  wire [31:0] exc_vector,
  input  wire        exc_return,
  input  wire        exc_pending,
  output wire        busy,
  output wire        exc_taken,
  // system bus
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg         mem_req,
  output reg         mem_write,
  input  wire [31:0] mem_rdata,
  input  wire        mem_ready,
  // visible mode
  output wire        handler_mode,
  output wire        stack_is_proc,
  output wire        exceptions_masked
);
  localparam ST_FETCH_SP = 3'h0;
  localparam ST_FETCH_PC = 3'h1;
  localparam ST_RUN      = 3'h2;
  localparam ST_PUSH     = 3'h3;
  localparam ST_STACK    = 3'h4;

  reg  [31:0] gp_r [0:12];
  reg  [31:0] main_sp_r;
  reg  [31:0] proc_sp_r;
  reg  [31:0] link_r;
  reg  [31:0] pc_r;
  reg  [3:0]  flags_r;
  reg  [5:0]  exc_num_r;
  reg         exec_state_r;
  reg         mask_r;
  reg         ctrl_sel_r;
  reg  [2:0]  state_r;
  reg  [2:0]  frame_idx_r;
  reg  [31:0] frame_word;
  wire [31:0] active_sp;
  wire        use_proc;
  wire [31:0] sp_dec;
  wire [31:0] status_all;
  wire [2:0]  frame_nxt_idx;
  wire        mem_done;
  wire        gp_sel;

  stack_select u_sel
  (
    .handler_mode   (handler_mode),
    .ctrl_stack_sel (ctrl_sel_r),
    .main_sp        (main_sp_r),
    .proc_sp        (proc_sp_r),
    .use_proc       (use_proc),
    .active_sp      (active_sp)
  );

  assign handler_mode      = (exc_num_r != `EXC_NUM_RESET);
  assign stack_is_proc     = use_proc;
  assign exceptions_masked = mask_r;
  assign sp_dec            = active_sp - `STACK_STEP;
  assign mem_done          = mem_req & mem_ready;
  assign busy              = (state_r != ST_RUN);
  assign exc_taken         = (state_r == ST_STACK) & mem_done
                             & (frame_idx_r == `STACK_FRAME_LEN);
  assign gp_sel            = (reg_sel <= `SEL_GP_LAST);
  assign status_all        = {flags_r, 3'h0, exec_state_r, 18'h00000,
                              exc_num_r};
  assign frame_nxt_idx     = frame_idx_r + 3'h1;

  // hardware frame order: r0..r3, r12, link, return pc, status (top first)
  // the word for the next slot is staged as each word completes, so a
  // zero-wait memory never takes stale write data
  always @*
  begin
    frame_word = status_all;
    case (frame_nxt_idx)
      3'h0: frame_word = status_all;
      3'h1: frame_word = pc_r;
      3'h2: frame_word = link_r;
      3'h3: frame_word = gp_r[12];
      3'h4: frame_word = gp_r[3];
      3'h5: frame_word = gp_r[2];
      3'h6: frame_word = gp_r[1];
      default: frame_word = gp_r[0];
    endcase
  end

  // read path; execution state reads as zero on its own view
  always @*
  begin
    reg_rdata = `ZERO_WORD;
    if (gp_sel)
      reg_rdata = gp_r[reg_sel[3:0]];
    else if (reg_sel == `SEL_STACK_PTR)
      reg_rdata = active_sp;
    else if (reg_sel == `SEL_RETURN_LINK)
      reg_rdata = link_r;
    else if (reg_sel == `SEL_INSTR_PTR)
      reg_rdata = pc_r;
    else if (reg_sel == `SEL_STATUS_ALL)
      reg_rdata = {flags_r, 22'h000000, exc_num_r};
    else if (reg_sel == `SEL_FLAGS)
      reg_rdata = {flags_r, 28'h0000000};
    else if (reg_sel == `SEL_EXC_NUM)
      reg_rdata = {26'h0000000, exc_num_r};
    else if (reg_sel == `SEL_EXC_MASK)
      reg_rdata = {31'h00000000, mask_r};
    else if (reg_sel == `SEL_CONTROL)
      reg_rdata = {30'h00000000, ctrl_sel_r, 1'b0};
    else if (reg_sel == `SEL_MAIN_SP)
      reg_rdata = main_sp_r;
    else if (reg_sel == `SEL_PROC_SP)
      reg_rdata = proc_sp_r;
  end

  // general registers: no reset, contents undefined until written
  always @(posedge clk_sys)
  begin
    if (reg_wr && gp_sel && !busy)
      gp_r[reg_sel[3:0]] <= reg_wdata;
  end

  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r     <= ST_FETCH_SP;
      exc_num_r   <= `EXC_NUM_RESET;
      mask_r      <= 1'b0;
      ctrl_sel_r  <= 1'b0;
      exec_state_r <= 1'b0;
      flags_r     <= 4'h0;
      frame_idx_r <= 3'h0;
      mem_req     <= 1'b1;
      mem_write   <= 1'b0;
      mem_addr    <= `ADDR_STACK_INIT;
      mem_wdata   <= `ZERO_WORD;
      main_sp_r   <= `ZERO_WORD;
      proc_sp_r   <= `ZERO_WORD;
      link_r      <= `ZERO_WORD;
      pc_r        <= `ZERO_WORD;
    end
    else
    begin
      case (state_r)
        ST_FETCH_SP:
          if (mem_done)
          begin
            main_sp_r <= mem_rdata;
            mem_addr  <= `ADDR_RESET_VEC;
            state_r   <= ST_FETCH_PC;
          end
        ST_FETCH_PC:
          if (mem_done)
          begin
            pc_r    <= {mem_rdata[31:1], 1'b0};
            exec_state_r <= mem_rdata[0];
            mem_req <= 1'b0;
            state_r <= ST_RUN;
          end
        ST_RUN:
        begin
          if (exc_req && !mask_r)
          begin
            // abandoned transfer resumes at its first word later
            if (multi_busy)
              pc_r <= multi_start_pc;
            frame_idx_r <= 3'h0;
            mem_req     <= 1'b1;
            mem_write   <= 1'b1;
            mem_addr    <= sp_dec;
            mem_wdata   <= status_all;
            state_r     <= ST_STACK;
          end
          else if (push_req)
          begin
            mem_req   <= 1'b1;
            mem_write <= 1'b1;
            mem_addr  <= sp_dec;
            mem_wdata <= push_data;
            state_r   <= ST_PUSH;
          end
          else if (exc_return && handler_mode && !exc_pending)
          begin
            exc_num_r <= `EXC_NUM_RESET;
            ctrl_sel_r <= (link_r == `EXC_RETURN_PSP);
          end
          else
          begin
            if (flags_wr)
              flags_r <= flags_in;
            if (pc_wr)
              pc_r <= pc_in;
            if (reg_wr)
            begin
              // stack pointer writes land in the selected bank only
              if (reg_sel == `SEL_STACK_PTR && use_proc)
                proc_sp_r <= reg_wdata;
              else if (reg_sel == `SEL_STACK_PTR)
                main_sp_r <= reg_wdata;
              else if (reg_sel == `SEL_MAIN_SP)
                main_sp_r <= reg_wdata;
              else if (reg_sel == `SEL_PROC_SP)
                proc_sp_r <= reg_wdata;
              else if (reg_sel == `SEL_RETURN_LINK)
                link_r <= reg_wdata;
              else if (reg_sel == `SEL_INSTR_PTR)
                pc_r <= reg_wdata;
              else if (reg_sel == `SEL_FLAGS ||
                       reg_sel == `SEL_STATUS_ALL)
                flags_r <= reg_wdata[`FLAGS_HI:`FLAGS_LO];
              else if (reg_sel == `SEL_EXC_MASK)
                mask_r <= reg_wdata[`MASK_BIT];
              else if (reg_sel == `SEL_CONTROL && !handler_mode)
                ctrl_sel_r <= reg_wdata[`CTRL_STACK_BIT];
            end
          end
        end
        ST_PUSH:
          if (mem_done)
          begin
            if (use_proc)
              proc_sp_r <= mem_addr;
            else
              main_sp_r <= mem_addr;
            mem_req   <= 1'b0;
            mem_write <= 1'b0;
            state_r   <= ST_RUN;
          end
        ST_STACK:
        begin
          if (mem_done)
          begin
            mem_wdata   <= frame_word;
            if (use_proc)
              proc_sp_r <= mem_addr;
            else
              main_sp_r <= mem_addr;
            mem_addr    <= mem_addr - `STACK_STEP;
            frame_idx_r <= frame_idx_r + 3'h1;
            if (frame_idx_r == `STACK_FRAME_LEN)
            begin
              link_r    <= use_proc ? `EXC_RETURN_PSP : `EXC_RETURN_VAL;
              exc_num_r <= exc_num;
              pc_r      <= {exc_vector[31:1], 1'b0};
              exec_state_r <= exc_vector[0];
              mem_req   <= 1'b0;
              mem_write <= 1'b0;
              state_r   <= ST_RUN;
            end
          end
        end
        default:
          state_r <= ST_RUN;
      endcase
    end
  end
endmodule

// file: rtl/core_state_defines.vh
`ifndef CORE_STATE_DEFINES_VH
`define CORE_STATE_DEFINES_VH

// register selector codes on the register access port
`define SEL_GP_LAST      5'h0C
`define SEL_STACK_PTR    5'h0D
`define SEL_RETURN_LINK  5'h0E
`define SEL_INSTR_PTR    5'h0F
`define SEL_STATUS_ALL   5'h10
`define SEL_FLAGS        5'h11
`define SEL_EXC_NUM      5'h12
`define SEL_EXEC_STATE   5'h13
`define SEL_EXC_MASK     5'h14
`define SEL_CONTROL      5'h15
`define SEL_MAIN_SP      5'h16
`define SEL_PROC_SP      5'h17

// field positions
`define FLAGS_HI         31
`define FLAGS_LO         28
`define EXC_NUM_HI       5
`define EXC_NUM_LO       0
`define EXEC_STATE_BIT   24
`define CTRL_STACK_BIT   1
`define MASK_BIT         0

// reset fetch addresses and reset values
`define ADDR_STACK_INIT  32'h00000000
`define ADDR_RESET_VEC   32'h00000004
`define EXC_NUM_RESET    6'h00
`define ZERO_WORD        32'h00000000
`define STACK_STEP       32'h00000004
`define STACK_FRAME_LEN  3'h7
`define EXC_RETURN_VAL   32'hFFFFFFF9
`define EXC_RETURN_PSP   32'hFFFFFFFD

`endif

// file: rtl/stack_select.v
`timescale 1ns/1ns
`include "core_state_defines.vh"

// picks the active stack pointer bank; handler mode forces the main stack
module stack_select
(
  input  wire        handler_mode,
  input  wire        ctrl_stack_sel,
  input  wire [31:0] main_sp,
  input  wire [31:0] proc_sp,
  output wire        use_proc,
  output wire [31:0] active_sp
);
  assign use_proc  = ~handler_mode & ctrl_stack_sel;
  assign active_sp = use_proc ? proc_sp : main_sp;
endmodule

// file: tb/mem_model.sv
`timescale 1ns/1ns
module mem_model
(
  input  wire        clk_sys,
  input  wire [3:0]  wait_cyc,
  input  wire        mem_req,
  input  wire        mem_write,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  output wire [31:0] mem_rdata,
  output wire        mem_ready
);
  reg [31:0] mem [0:63];
  reg [3:0]  cnt_r;
  initial
  begin
    cnt_r = 4'h0;
    mem[0] = 32'h00000100;
    mem[1] = 32'h00000041;
  end
  assign mem_ready = mem_req && (cnt_r >= wait_cyc);
  // read data is only good with ready; otherwise show its inverse
  assign mem_rdata = mem_ready ? mem[mem_addr[7:2]] : ~mem[mem_addr[7:2]];
  always @(posedge clk_sys)
  begin
    // an unknown request before the first reset edge must not poison cnt_r
    cnt_r <= (mem_req !== 1'b1 || mem_ready) ? 4'h0 : cnt_r + 4'h1;
    if (mem_ready && mem_write)
      mem[mem_addr[7:2]] <= mem_wdata;
  end
endmodule

// file: tb/core_chk.sv
`timescale 1ns/1ns
`include "core_state_defines.vh"
module core_chk
(
  input wire        clk_sys,
  input wire        reset,
  input wire [4:0]  reg_sel,
  input wire [31:0] reg_rdata,
  input wire        mem_req,
  input wire        mem_write,
  input wire [31:0] mem_addr,
  input wire        mem_ready,
  input wire        exc_taken,
  input wire        handler_mode,
  input wire        stack_is_proc,
  input wire        exceptions_masked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  boot_fetch_a: assert property (
    $fell(reset) |-> mem_req && !mem_write
      && mem_addr == `ADDR_STACK_INIT)
    else $error("reset fetch not at zero");
  boot_mode_a: assert property (
    $fell(reset) |-> !handler_mode && !stack_is_proc)
    else $error("bad mode after reset");
  handler_main_a: assert property (
    handler_mode |-> !stack_is_proc)
    else $error("handler not on main stack");
  ctrl_sel_a: assert property (
    reg_sel == `SEL_CONTROL && !handler_mode
      |-> stack_is_proc == reg_rdata[1])
    else $error("stack select mismatch");
  excnum_mode_a: assert property (
    reg_sel == `SEL_EXC_NUM
      |-> handler_mode == (reg_rdata[5:0] != 6'h00))
    else $error("mode and number disagree");
  exec_zero_a: assert property (
    reg_sel == `SEL_EXEC_STATE |-> reg_rdata == 32'h00000000)
    else $error("state read not zero");
  mask_view_a: assert property (
    reg_sel == `SEL_EXC_MASK |-> exceptions_masked == reg_rdata[0])
    else $error("mask view mismatch");
  bus_hold_a: assert property (
    mem_req && !mem_ready
      |=> mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("bus request dropped");
  entry_mode_a: assert property (
    exc_taken |-> !exceptions_masked ##[1:2] handler_mode)
    else $error("entry without handler");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
`include "core_state_defines.vh"
module tb_top;
  reg         clk_sys, reset, reg_wr, push_req, flags_wr, pc_wr;
  reg         multi_busy, exc_req, exc_return, exc_pending;
  reg  [4:0]  reg_sel;
  reg  [3:0]  flags_in, wait_cyc;
  reg  [5:0]  exc_num;
  reg  [31:0] reg_wdata, push_data, pc_in, multi_start_pc, exc_vector;
  wire [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
  wire        busy, exc_taken, mem_req, mem_write, mem_ready;
  wire        handler_mode, stack_is_proc, exceptions_masked;
  integer     error_cnt, comparisons, n;
  core_mode_stack_registers u_dut (.clk_sys(clk_sys), .reset(reset),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .push_req(push_req), .push_data(push_data),
    .flags_wr(flags_wr), .flags_in(flags_in), .pc_wr(pc_wr), .pc_in(pc_in),
    .multi_busy(multi_busy), .multi_start_pc(multi_start_pc),
    .exc_req(exc_req), .exc_num(exc_num), .exc_vector(exc_vector),
    .exc_return(exc_return), .exc_pending(exc_pending), .busy(busy),
    .exc_taken(exc_taken), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_req(mem_req), .mem_write(mem_write), .mem_rdata(mem_rdata),
    .mem_ready(mem_ready), .handler_mode(handler_mode),
    .stack_is_proc(stack_is_proc), .exceptions_masked(exceptions_masked));
  mem_model u_mem (.clk_sys(clk_sys), .wait_cyc(wait_cyc),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready));
  task give_verdict;
  begin
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task idle;
  begin
    n = 0;
    while (busy !== 1'b0 && n < 300)
    begin
      @(posedge clk_sys) #1;
      n = n + 1;
    end
    if (n == 300)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: busy never cleared", $time);
      give_verdict;
    end
  end
  endtask
  task rd(input [4:0] s, input [31:0] exp);
  begin
    @(posedge clk_sys) #1 reg_sel = s;
    #1 chk(reg_rdata, exp);
  end
  endtask
  task wr(input [4:0] s, input [31:0] d);
  begin
    @(posedge clk_sys) #1 reg_sel = s;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys) #1 reg_wr = 1'b0;
  end
  endtask
  // one-cycle request: bit 0 push, bit 1 exception, bit 2 return
  task strobe(input [2:0] k);
  begin
    @(posedge clk_sys) #1 {exc_return, exc_req, push_req} = k;
    @(posedge clk_sys) #1 {exc_return, exc_req, push_req} = 3'h0;
    idle;
  end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    {reg_wr, push_req, flags_wr, pc_wr, multi_busy} = 5'h00;
    {exc_req, exc_return, exc_pending, flags_in} = 7'h00;
    {reg_sel, wait_cyc, reg_wdata, push_data, pc_in} = 0;
    multi_start_pc = 32'h00000060;
    exc_vector = 32'h00000081;
    exc_num = 6'h10;
    error_cnt = 0;
    comparisons = 0;
    reset = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 reset = 1'b0;
    idle;
    rd(`SEL_MAIN_SP, 32'h00000100);
    rd(`SEL_INSTR_PTR, 32'h00000040);
    rd(`SEL_CONTROL, 32'h00000000);
    rd(`SEL_EXC_NUM, 32'h00000000);
    rd(`SEL_EXEC_STATE, 32'h00000000);
    $display("test boot done");
    wr(5'h03, 32'h33333333);
    rd(5'h03, 32'h33333333);
    wr(`SEL_EXC_NUM, 32'h00000005);
    rd(`SEL_EXC_NUM, 32'h00000000);
    push_data = 32'h000000A5;
    strobe(3'h1);
    rd(`SEL_MAIN_SP, 32'h000000FC);
    chk(u_mem.mem[63], 32'h000000A5);
    wr(`SEL_CONTROL, 32'h00000002);
    chk({31'h0, stack_is_proc}, 32'h00000001);
    wr(`SEL_PROC_SP, 32'h00000080);
    strobe(3'h1);
    rd(`SEL_STACK_PTR, 32'h0000007C);
    rd(`SEL_MAIN_SP, 32'h000000FC);
    $display("test stacks done");
    wait_cyc = 4'h2;
    multi_busy = 1'b1;
    strobe(3'h2);
    multi_busy = 1'b0;
    chk({31'h0, handler_mode}, 32'h00000001);
    rd(`SEL_STACK_PTR, 32'h000000FC);
    rd(`SEL_PROC_SP, 32'h0000005C);
    chk(u_mem.mem[29], 32'h00000060);
    chk(u_mem.mem[26], 32'h33333333);
    rd(`SEL_EXC_NUM, 32'h00000010);
    exc_pending = 1'b1;
    strobe(3'h4);
    chk({31'h0, handler_mode}, 32'h00000001);
    exc_pending = 1'b0;
    strobe(3'h4);
    chk({30'h0, handler_mode, stack_is_proc}, 32'h00000001);
    $display("test exception done");
    wr(`SEL_EXC_MASK, 32'h00000001);
    strobe(3'h2);
    chk({31'h0, handler_mode}, 32'h00000000);
    rd(`SEL_EXC_MASK, 32'h00000001);
    $display("test mask done");
    wr(`SEL_EXC_MASK, 32'h00000000);
    wr(`SEL_FLAGS, 32'hA0000000);
    rd(`SEL_STATUS_ALL, 32'hA0000000);
    wait_cyc = 4'h0;
    strobe(3'h2);
    chk(u_mem.mem[22], 32'hA1000000);
    chk(u_mem.mem[21], 32'h00000080);
    rd(`SEL_RETURN_LINK, 32'hFFFFFFFD);
    rd(`SEL_PROC_SP, 32'h0000003C);
    $display("test zero wait done");
    give_verdict;
  end
endmodule
bind core_mode_stack_registers core_chk u_chk (.clk_sys(clk_sys),
  .reset(reset), .reg_sel(reg_sel), .reg_rdata(reg_rdata),
  .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
  .mem_ready(mem_ready), .exc_taken(exc_taken),
  .handler_mode(handler_mode), .stack_is_proc(stack_is_proc),
  .exceptions_masked(exceptions_masked));
